// [dv/stc_sec_partner.sv]
// Neighbouring device model: 8 kHz reference source and one-second loopback.
// Assumes it shares CLK_I with the block; one reference period is 12 cycles.
`timescale 1ns/1ns
module stc_sec_partner (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic go_i,
    input wire logic [7:0] periods_i,
    output logic done_o,
    // Pins
    input wire logic second_pulse_i,
    output logic ref_o,
    output logic sync_o
);
    logic [7:0] left;
    logic [3:0] ph;
    logic [2:0] scnt;
    // Whole periods only; reference stands low when idle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            left <= 8'h00;
            ph <= 4'h0;
        end
        else if (go_i)
        begin
            left <= periods_i;
            ph <= 4'h0;
        end
        else if (left != 8'h00)
        begin
            ph <= (ph == 4'hb) ? 4'h0 : ph + 4'h1;
            if (ph == 4'hb)
                left <= left - 8'h01;
        end
    end
    // board loopback
    // Stretched so the pin filter sees it
    always @(posedge clk_i)
        scnt <= rst_i ? 3'h0 : second_pulse_i ? 3'h4 : (scnt != 3'h0) ? scnt - 3'h1 : 3'h0;
    assign sync_o = scnt != 3'h0;
    assign ref_o = (left != 8'h00) && (ph < 4'h6);
    assign done_o = left == 8'h00;
endmodule : stc_sec_partner

// [dv/testbench.sv]
// Self-checking bench for the status timing and reset control block.
// Assumes one-second count shortened to 4 reference edges.
`timescale 1ns/1ns
module testbench;
    import stc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, hold = 1'b0, frm = 1'b0, loss = 1'b0;
    logic cs_n = 1'b1, wr = 1'b0, go = 1'b0, clr = 1'b0;
    logic [3:0] req = 4'h0;
    logic [6:0] adr = 7'h00;
    logic [15:0] wd = 16'h0000;
    logic sec, lat, valid, tick, mrk, out_of_frame_state, loop, oe, refc, sync, done;
    logic [3:0] strb;
    logic [15:0] rd;
    logic [7:0] n_sec, n_lat, n_tick, n_mrk;
    int mismatches = 0;
    int n_tests = 0;
    always #10 clk = ~clk;
    stc_top #(.SEC_REF_COUNT(4)) u_stc_top (.CLK_I(clk), .SYS_RST_I(rst),
        .FRAME_REF_CLOCK_IN_I(refc), .SECOND_SYNC_IN_I(sync), .RECEIVER_HOLD_IN_I(hold),
        .SECOND_PULSE_OUT_O(sec), .STATUS_LATCH_O(lat), .CELL_VALID_EN_O(valid),
        .PLCP_REF_TICK_O(tick), .RX_PLCP_FRAME_I(frm), .RX_FRAME_LOSS_I(loss),
        .RECEIVE_FRAME_MARKER_O(mrk), .OUT_OF_FRAME_STATE_O(out_of_frame_state), .LINE_LOOPBACK_O(loop),
        .FIFO_RD_REQ_I(req), .FIFO_RD_STROBE_N_O(strb), .REG_CS_N_I(cs_n),
        .REG_WR_RD_N_I(wr), .REG_ADDR_I(adr), .REG_DATA_I(wd), .REG_DATA_O(rd),
        .REG_DATA_OE_O(oe));
    stc_sec_partner u_stc_sec_partner (.clk_i(clk), .rst_i(rst), .go_i(go),
        .periods_i(8'h20), .done_o(done), .second_pulse_i(sec), .ref_o(refc), .sync_o(sync));
    // Pulse counters, cleared by the sequence
    always @(posedge clk)
    begin
        n_sec <= clr ? 8'h00 : n_sec + {7'h00, sec};
        n_lat <= clr ? 8'h00 : n_lat + {7'h00, lat};
        n_tick <= clr ? 8'h00 : n_tick + {7'h00, tick};
        n_mrk <= clr ? 8'h00 : n_mrk + {7'h00, mrk};
    end
    task stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task wr_reg(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk);
        cs_n = 1'b0;
        wr = 1'b1;
        adr = a;
        wd = d;
        @(negedge clk);
        cs_n = 1'b1;
        wr = 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [6:0] a, input logic [15:0] exp, input string m);
        @(negedge clk);
        cs_n = 1'b0;
        adr = a;
        @(negedge clk);
        chk({15'h0, oe}, 16'h0001, "read enable");
        chk(rd, exp, m);
        cs_n = 1'b1;
    endtask : rd_reg
    task frame();
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        frm = 1'b1;
        cyc(1);
        frm = 1'b0;
        cyc(3);
    endtask : frame
    initial
    begin
        req = 4'hf;
        cyc(4);
        chk({12'h0, strb}, 16'h000f, "strobes in reset");
        cyc(4);
        rst = 1'b0;
        req = 4'h0;
        rd_reg(STC_ADDR_FEAV, {8'h00, STC_REVISION}, "revision");
        wr_reg(STC_ADDR_FEAV, 16'hffff);
        rd_reg(STC_ADDR_FEAV, {8'h00, STC_REVISION}, "revision kept");
        rd_reg(7'h30, 16'h0000, "unmapped read");
        wr_reg(STC_ADDR_LINE_CFG, 16'h0200);
        rd_reg(STC_ADDR_LINE_CFG, 16'h0200, "loopback set");
        chk({15'h0, loop}, 16'h0001, "loopback pin set");
        rst = 1'b1;
        cyc(8);
        rst = 1'b0;
        cyc(1);
        chk({15'h0, loop}, 16'h0000, "loopback after reset");
        rd_reg(STC_ADDR_LINE_CFG, 16'h0000, "line config after reset");
        $display("register test done");
        req = 4'h5;
        cyc(2);
        chk({12'h0, strb}, 16'h000a, "strobes follow requests");
        wr_reg(STC_ADDR_LINE_CFG, 16'h0200);
        wr_reg(STC_ADDR_CFG5, 16'h0080);
        cyc(2);
        chk({12'h0, strb}, 16'h000f, "strobes in soft reset");
        chk({15'h0, loop}, 16'h0000, "loopback in soft reset");
        wr_reg(STC_ADDR_CFG5, 16'h0000);
        cyc(2);
        chk({12'h0, strb}, 16'h000a, "strobes after soft reset");
        req = 4'h0;
        chk({15'h0, valid}, 16'h0001, "validation on");
        hold = 1'b1;
        cyc(8);
        chk({15'h0, valid}, 16'h0000, "validation held");
        rd_reg(STC_ADDR_STATUS, 16'h0003, "hold and out of frame status");
        hold = 1'b0;
        cyc(8);
        chk({15'h0, valid}, 16'h0001, "validation resumed");
        $display("reset and hold test done");
        wr_reg(STC_ADDR_CFG5, 16'h0003);
        cyc(3);
        chk({15'h0, out_of_frame_state}, 16'h0001, "out of frame on plcp entry");
        frame();
        chk({8'h0, n_mrk}, 16'h0001, "marker per frame");
        chk({15'h0, out_of_frame_state}, 16'h0000, "in frame");
        loss = 1'b1;
        cyc(1);
        loss = 1'b0;
        cyc(3);
        chk({15'h0, out_of_frame_state}, 16'h0001, "out of frame on loss");
        frame();
        wr_reg(STC_ADDR_CFG5, 16'h0002);
        wr_reg(STC_ADDR_CFG5, 16'h0003);
        cyc(3);
        chk({15'h0, out_of_frame_state}, 16'h0001, "dynamic plcp switch");
        wr_reg(STC_ADDR_CFG5, 16'h0007);
        frame();
        chk({8'h0, n_mrk}, 16'h0000, "no marker in direct map");
        $display("framer test done");
        wr_reg(STC_ADDR_CFG5, 16'h0003);
        clr = 1'b1;
        go = 1'b1;
        cyc(1);
        clr = 1'b0;
        go = 1'b0;
        cyc(1);
        for (int i = 0; i < 2000 && done !== 1'b1; i++)
            cyc(1);
        // A hang skips the counts and still ends in the one verdict
        if (done !== 1'b1)
        begin
            mismatches++;
            $display("unexpected at %0t: reference run hung", $time);
        end
        else
        begin
            cyc(20);
            chk({8'h0, n_sec}, 16'h0008, "second pulses");
            chk({8'h0, n_lat}, 16'h0008, "status latches");
            chk({8'h0, n_tick}, 16'h0020, "plcp reference ticks");
            $display("one-second test done");
        end
        stop_test();
    end
endmodule : testbench

// [rtl/stc_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter and rise pulse.
// Assumes the pin is asynchronous to CLK_I.
`timescale 1ns/1ns
module stc_pin_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pin and results
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o
);
    logic s1;
    logic s2;
    logic s3;

    // First stage feeds only the second
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end
        else
        begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Change counts once stages two and three agree
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            level_o <= 1'b0;
            rise_o <= 1'b0;
        end
        else
        begin
            rise_o <= (s2 == s3) && s2 && !level_o;
            if (s2 == s3)
            begin
                level_o <= s2;
            end
        end
    end
endmodule : stc_pin_sync

// [rtl/stc_pkg.sv]
// Shared constants for the status timing and reset control block.
// Assumes a single 50 MHz system clock and a word-addressed register port.
package stc_pkg;

    // Register word addresses on the processor port
    localparam logic [6:0] STC_ADDR_LINE_CFG = 7'h02;
    localparam logic [6:0] STC_ADDR_CFG5 = 7'h04;
    localparam logic [6:0] STC_ADDR_FEAV = 7'h0a;
    localparam logic [6:0] STC_ADDR_STATUS = 7'h0c;

    localparam int STC_DATA_W = 16;
    localparam int STC_ADDR_W = 7;
    localparam int STC_PORTS = 4;

    // Field positions
    localparam int STC_LINE_LOOPBACK_BIT = 9;
    localparam int STC_CFG5_PLCP_BIT = 0;
    localparam int STC_CFG5_RATE_E3DS3_BIT = 1;
    localparam int STC_CFG5_DIRECT_MAP_BIT = 2;
    localparam int STC_CFG5_SOFT_RST_BIT = 7;
    localparam int STC_STAT_OOF_BIT = 0;
    localparam int STC_STAT_HOLD_BIT = 1;
    localparam int STC_STAT_SYNC_BIT = 2;
    localparam int STC_STAT_REF_BIT = 3;

    // Reset values
    localparam logic [15:0] STC_LINE_CFG_RST = 16'h0000;
    localparam logic [15:0] STC_CFG5_RST = 16'h0000;

    // Revision code, value arbitrary
    localparam logic [7:0] STC_REVISION = 8'h5a;

    // Reference edges per second: 8 kHz for one second
    localparam int STC_REF_HZ = 8000;
    localparam int STC_SEC_SECONDS = 1;
    localparam int STC_REF_PER_SEC = STC_REF_HZ * STC_SEC_SECONDS;
    localparam int STC_SEC_CNT_W = 14;

    typedef enum logic [0:0] {
        STC_ST_OOF,
        STC_ST_INFRAME
    } stc_frame_t;

endpackage : stc_pkg

// [rtl/stc_top.sv]
// Status timing, receive marker and reset control of the cell transceiver.
// Assumes a processor port synchronous to CLK_I and framer strobes on CLK_I.
`timescale 1ns/1ns
module stc_top #(
    parameter int SEC_REF_COUNT = stc_pkg::STC_REF_PER_SEC
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // Clock and control pins
    input wire logic FRAME_REF_CLOCK_IN_I,
    input wire logic SECOND_SYNC_IN_I,
    input wire logic RECEIVER_HOLD_IN_I,
    output logic SECOND_PULSE_OUT_O,
    output logic STATUS_LATCH_O,
    output logic CELL_VALID_EN_O,
    output logic PLCP_REF_TICK_O,
    // Receive framer side
    input wire logic RX_PLCP_FRAME_I,
    input wire logic RX_FRAME_LOSS_I,
    output logic RECEIVE_FRAME_MARKER_O,
    output logic OUT_OF_FRAME_STATE_O,
    output logic LINE_LOOPBACK_O,
    // FIFO read strobes
    input wire logic [stc_pkg::STC_PORTS-1:0] FIFO_RD_REQ_I,
    output logic [stc_pkg::STC_PORTS-1:0] FIFO_RD_STROBE_N_O,
    // Processor port
    input wire logic REG_CS_N_I,
    input wire logic REG_WR_RD_N_I,
    input wire logic [stc_pkg::STC_ADDR_W-1:0] REG_ADDR_I,
    input wire logic [stc_pkg::STC_DATA_W-1:0] REG_DATA_I,
    output logic [stc_pkg::STC_DATA_W-1:0] REG_DATA_O,
    output logic REG_DATA_OE_O
);
    import stc_pkg::*;

    logic [15:0] line_cfg;
    logic [15:0] cfg5;
    logic rst_all;
    logic ref_level;
    logic ref_rise;
    logic sync_level;
    logic sync_rise;
    logic hold_level;
    logic [STC_SEC_CNT_W-1:0] sec_cnt;
    logic plcp_prev;
    stc_frame_t frame_st;
    logic wr_en;
    logic rd_en;

    function automatic logic [15:0] read_mux(input logic [6:0] addr,
        input logic [15:0] lc, input logic [15:0] c5, input logic [15:0] st);
        case (addr)
            STC_ADDR_LINE_CFG: read_mux = lc;
            STC_ADDR_CFG5: read_mux = c5;
            STC_ADDR_FEAV: read_mux = {8'h00, STC_REVISION};
            STC_ADDR_STATUS: read_mux = st;
            default: read_mux = 16'h0000;
        endcase
    endfunction : read_mux

    assign rst_all = SYS_RST_I || cfg5[STC_CFG5_SOFT_RST_BIT];
    assign wr_en = !REG_CS_N_I && REG_WR_RD_N_I;
    assign rd_en = !REG_CS_N_I && !REG_WR_RD_N_I;

    stc_pin_sync u_ref_sync (
        .clk_i(CLK_I),
        .rst_i(rst_all),
        .pin_i(FRAME_REF_CLOCK_IN_I),
        .level_o(ref_level),
        .rise_o(ref_rise)
    );
    stc_pin_sync u_sec_sync (
        .clk_i(CLK_I),
        .rst_i(rst_all),
        .pin_i(SECOND_SYNC_IN_I),
        .level_o(sync_level),
        .rise_o(sync_rise)
    );
    stc_pin_sync u_hold_sync (
        .clk_i(CLK_I),
        .rst_i(rst_all),
        .pin_i(RECEIVER_HOLD_IN_I),
        .level_o(hold_level),
        .rise_o()
    );

    // Config five survives its own soft reset so software can release it
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            cfg5 <= STC_CFG5_RST;
        end
        else if (wr_en && REG_ADDR_I == STC_ADDR_CFG5)
        begin
            cfg5 <= REG_DATA_I;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (rst_all)
        begin
            line_cfg <= STC_LINE_CFG_RST;
        end
        else if (wr_en && REG_ADDR_I == STC_ADDR_LINE_CFG)
        begin
            line_cfg <= REG_DATA_I;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            REG_DATA_O <= 16'h0000;
            REG_DATA_OE_O <= 1'b0;
        end
        else
        begin
            REG_DATA_OE_O <= rd_en;
            REG_DATA_O <= rd_en ? read_mux(REG_ADDR_I, line_cfg, cfg5,
                {12'h000, ref_level, sync_level, hold_level,
                 frame_st == STC_ST_OOF}) : 16'h0000;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (rst_all)
        begin
            sec_cnt <= '0;
            SECOND_PULSE_OUT_O <= 1'b0;
        end
        else
        begin
            SECOND_PULSE_OUT_O <= 1'b0;
            if (ref_rise)
            begin
                if (sec_cnt == STC_SEC_CNT_W'(SEC_REF_COUNT - 1))
                begin
                    sec_cnt <= '0;
                    SECOND_PULSE_OUT_O <= 1'b1;
                end
                else
                begin
                    sec_cnt <= sec_cnt + 1'b1;
                end
            end
        end
    end

    // PLCP timing tick at E3 and DS3
    always_ff @(posedge CLK_I)
    begin
        if (rst_all)
        begin
            STATUS_LATCH_O <= 1'b0;
            PLCP_REF_TICK_O <= 1'b0;
        end
        else
        begin
            STATUS_LATCH_O <= sync_rise;
            PLCP_REF_TICK_O <= ref_rise && cfg5[STC_CFG5_PLCP_BIT]
                && cfg5[STC_CFG5_RATE_E3DS3_BIT];
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (rst_all)
        begin
            CELL_VALID_EN_O <= 1'b0;
        end
        else
        begin
            CELL_VALID_EN_O <= !hold_level;
        end
    end

    // PLCP switch forces out of frame
    always_ff @(posedge CLK_I)
    begin
        if (rst_all)
        begin
            frame_st <= STC_ST_OOF;
            plcp_prev <= 1'b0;
        end
        else
        begin
            plcp_prev <= cfg5[STC_CFG5_PLCP_BIT];
            case (frame_st)
                STC_ST_OOF:
                    if (RX_PLCP_FRAME_I && plcp_prev && cfg5[STC_CFG5_PLCP_BIT])
                    begin
                        frame_st <= STC_ST_INFRAME;
                    end
                STC_ST_INFRAME:
                    if (RX_FRAME_LOSS_I || (cfg5[STC_CFG5_PLCP_BIT] && !plcp_prev)
                        || !cfg5[STC_CFG5_PLCP_BIT])
                    begin
                        frame_st <= STC_ST_OOF;
                    end
                default: frame_st <= STC_ST_OOF;
            endcase
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (rst_all)
        begin
            RECEIVE_FRAME_MARKER_O <= 1'b0;
            OUT_OF_FRAME_STATE_O <= 1'b1;
            LINE_LOOPBACK_O <= 1'b0;
        end
        else
        begin
            RECEIVE_FRAME_MARKER_O <= RX_PLCP_FRAME_I
                && !cfg5[STC_CFG5_DIRECT_MAP_BIT];
            OUT_OF_FRAME_STATE_O <= (frame_st == STC_ST_OOF);
            LINE_LOOPBACK_O <= line_cfg[STC_LINE_LOOPBACK_BIT];
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (rst_all)
        begin
            FIFO_RD_STROBE_N_O <= '1;
        end
        else
        begin
            FIFO_RD_STROBE_N_O <= ~FIFO_RD_REQ_I;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    property p_strobe_rst;
        cfg5[STC_CFG5_SOFT_RST_BIT] |=> (FIFO_RD_STROBE_N_O == '1);
    endproperty
    a_strobe_rst: assert property (p_strobe_rst) else $error("strobe active in reset");
    property p_loop_clr;
        $past(rst_all) |-> !line_cfg[STC_LINE_LOOPBACK_BIT];
    endproperty
    a_loop_clr: assert property (p_loop_clr) else $error("loopback not cleared");
    property p_marker_direct;
        cfg5[STC_CFG5_DIRECT_MAP_BIT] && $stable(cfg5) |=> !RECEIVE_FRAME_MARKER_O;
    endproperty
    a_marker_direct: assert property (p_marker_direct) else $error("marker in direct");
    property p_marker_frame;
        RX_PLCP_FRAME_I && !cfg5[STC_CFG5_DIRECT_MAP_BIT] && !rst_all
            |=> RECEIVE_FRAME_MARKER_O;
    endproperty
    a_marker_frame: assert property (p_marker_frame) else $error("marker missing");
    property p_plcp_oof;
        $rose(cfg5[STC_CFG5_PLCP_BIT]) && !rst_all |=> frame_st == STC_ST_OOF;
    endproperty
    a_plcp_oof: assert property (p_plcp_oof) else $error("no oof on switch");
    property p_hold;
        hold_level && !rst_all |=> !CELL_VALID_EN_O;
    endproperty
    a_hold: assert property (p_hold) else $error("validation not held");
    property p_sec;
        SECOND_PULSE_OUT_O |-> $past(ref_rise) && $past(sec_cnt) ==
            STC_SEC_CNT_W'(SEC_REF_COUNT - 1) && sec_cnt == '0;
    endproperty
    a_sec: assert property (p_sec) else $error("second pulse misplaced");
    property p_latch;
        sync_rise && !rst_all |=> STATUS_LATCH_O ##1 !STATUS_LATCH_O;
    endproperty
    a_latch: assert property (p_latch) else $error("latch not from sync");
    property p_rev;
        rd_en && REG_ADDR_I == STC_ADDR_FEAV |=> REG_DATA_O[7:0] == STC_REVISION
            && REG_DATA_OE_O;
    endproperty
    a_rev: assert property (p_rev) else $error("revision wrong");
    property p_tick;
        PLCP_REF_TICK_O |-> $past(ref_rise) && $past(cfg5[STC_CFG5_RATE_E3DS3_BIT]);
    endproperty
    a_tick: assert property (p_tick) else $error("plcp tick without ref");

    c_sec: cover property (SECOND_PULSE_OUT_O);
    c_lock: cover property (frame_st == STC_ST_OOF ##1 frame_st == STC_ST_INFRAME);
    c_soft: cover property ($rose(cfg5[STC_CFG5_SOFT_RST_BIT]));
endmodule : stc_top
